// ---- inc/arc_pkg.sv ----
// Package: constants for the converter control block
package arc_pkg;
	// Clock and oscillator
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned OSC_HZ = 1_000_000;
	localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
	localparam int unsigned TICKS_PER_US = OSC_HZ / 1_000_000;
	// Power-up time and ready pulse, in microseconds and in oscillator ticks
	localparam int unsigned PWRUP_US = 25;
	localparam int unsigned READY_US = 8;
	localparam int unsigned PWRUP_TICKS = PWRUP_US * TICKS_PER_US;
	localparam int unsigned READY_TICKS = READY_US * TICKS_PER_US;
	localparam int TW = 13;
	// Data rates and conversion lengths
	localparam int unsigned RATE_SPS [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};
	localparam logic [12:0] RATE_TICKS [8] = '{
		13'(OSC_HZ / RATE_SPS[0]), 13'(OSC_HZ / RATE_SPS[1]),
		13'(OSC_HZ / RATE_SPS[2]), 13'(OSC_HZ / RATE_SPS[3]),
		13'(OSC_HZ / RATE_SPS[4]), 13'(OSC_HZ / RATE_SPS[5]),
		13'(OSC_HZ / RATE_SPS[6]), 13'(OSC_HZ / RATE_SPS[7])};
	// Full-scale spans in mV and code step in uV (span doubled over 2^12 codes)
	localparam int unsigned FSR_MV [8] = '{6144, 4096, 2048, 1024, 512, 256, 256, 256};
	localparam int unsigned UV_PER_SPAN_MV = 2000;
	localparam int unsigned CODE_LEVELS = 4096;
	localparam logic [2:0] FIXED_GAIN = 3'h2;
	// Register offsets
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_CONFIG = 5'h04;
	localparam logic [4:0] OFF_LOWER = 5'h08;
	localparam logic [4:0] OFF_UPPER = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	// Configuration fields
	localparam int CF_START = 15;
	localparam int CF_GAIN = 9;
	localparam int CF_MODE = 8;
	localparam int CF_RATE = 5;
	localparam int CF_WIN = 4;
	localparam int CF_POL = 3;
	localparam int CF_LATCH = 2;
	localparam int CF_QUE = 0;
	// Reset values
	localparam logic [15:0] CFG_RST = 16'h0583;
	localparam logic [15:0] LOWER_RST = 16'h8000;
	localparam logic [15:0] UPPER_RST = 16'h7FFF;
	// Assertion queue codes and counts
	localparam logic [1:0] Q_ONE = 2'h0;
	localparam logic [1:0] Q_TWO = 2'h1;
	localparam logic [1:0] Q_OFF = 2'h3;
	localparam logic [2:0] N_ONE = 3'h1;
	localparam logic [2:0] N_TWO = 3'h2;
	localparam logic [2:0] N_FOUR = 3'h4;
	// Two-wire bus bytes
	localparam logic [7:0] ARA_RD_BYTE = 8'h19;
	localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
	localparam logic [7:0] GC_RESET_BYTE = 8'h06;
endpackage : arc_pkg

// ---- inc/arc_conv_if.sv ----
// Interface: link between control logic and conversion timer
`timescale 1ns/1ps
interface arc_conv_if;
	logic tick;
	logic clr;
	logic go;
	logic cont_en;
	logic [arc_pkg::TW-1:0] period;
	logic conv_start;
	logic conv_done;
	logic busy;
	modport tmr (input tick, input clr, input go, input cont_en, input period,
		output conv_start, output conv_done, output busy);
	modport ctl (output tick, output clr, output go, output cont_en, output period,
		input conv_start, input conv_done, input busy);
endinterface : arc_conv_if

// ---- design/arc_conv_timer.sv ----
// Conversion timer: power-up delay and conversion length in oscillator ticks
`timescale 1ns/1ps
module arc_conv_timer (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	arc_conv_if.tmr bus
);
	typedef enum logic [1:0] {TM_IDLE, TM_PWRUP, TM_CONV} arc_tm_t;
	arc_tm_t st_reg;
	logic [arc_pkg::TW-1:0] cnt_reg;

	// A start request while busy is simply not seen
	assign bus.busy = (st_reg != TM_IDLE);

	// Sequencer; the length is loaded at each start, so a later write waits
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= TM_IDLE;
			cnt_reg <= '0;
			bus.conv_start <= 1'b0;
			bus.conv_done <= 1'b0;
		end else begin
			bus.conv_start <= 1'b0;
			bus.conv_done <= 1'b0;
			if (bus.clr) begin
				st_reg <= TM_IDLE;
			end else begin
				unique case (st_reg)
					TM_IDLE: begin
						if (bus.go || bus.cont_en) begin
							st_reg <= TM_PWRUP;
							cnt_reg <= arc_pkg::TW'(arc_pkg::PWRUP_TICKS - 1);
						end
					end
					TM_PWRUP: begin
						if (bus.tick) begin
							if (cnt_reg == '0) begin
								st_reg <= TM_CONV;
								cnt_reg <= bus.period - 1'b1;
								bus.conv_start <= 1'b1;
							end else begin
								cnt_reg <= cnt_reg - 1'b1;
							end
						end
					end
					TM_CONV: begin
						if (bus.tick) begin
							if (cnt_reg == '0) begin
								bus.conv_done <= 1'b1;
								if (bus.cont_en) begin
									cnt_reg <= bus.period - 1'b1;
									bus.conv_start <= 1'b1;
								end else begin
									st_reg <= TM_IDLE;
								end
							end else begin
								cnt_reg <= cnt_reg - 1'b1;
							end
						end
					end
				endcase
			end
		end
	end
endmodule : arc_conv_timer

// ---- design/arc_ctrl_top.sv ----
// Converter control: range, rate timing, comparator, alert pin and alert response
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Gain field picks one of six spans; no-gain build stays at 2.048 V
// - Code step follows span: 3, 2, 1, 0.5, 0.25, 0.125 mV
// - All timing comes from a 1 MHz oscillator tick
// - Rate field selects 128 to 3300 samples per second
// - One conversion lasts the reciprocal of the data rate
// - Traditional: assert above upper limit, release only below lower limit
// - Window: assert when above upper or below lower limit
// - Window bit picks traditional or window comparison
// - Latch bit keeps the alert asserted after it is raised
// - Latched alert clears on data read or alert-response win; may reassert
// - Polarity bit picks active high or low; low is default
// - Queue needs 1, 2 or 4 violations; 11b disables and releases pin
// - Upper MSB 1, lower MSB 0, queue enabled: pin shows ready
// - Continuous ready mode gives an 8 us pulse per conversion
// - Single-shot ready mode asserts the pin at conversion end
// - Alert response read 0x19 is answered with own address when latched
// - Lowest address wins arbitration; only the winner clears its alert
// - Window mode status bit is 1 for upper, 0 for lower violation
// - After reset, defaults load and the converter stays powered down
// - General-call reset byte 06h resets as at power-up, except the range outputs and the upper/lower flag, which hold
// - Mode bit selects continuous or single-shot conversion
// - Start flag powers up in 25 us, runs one conversion; ignored busy
// - New settings apply from the next conversion in continuous mode
module arc_ctrl_top #(
	parameter bit HAS_GAIN = 1'b1,
	parameter int unsigned OSC_DIV = arc_pkg::OSC_DIV
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_b_o,
	input wire logic [6:0] dev_addr_i,
	input wire logic [11:0] conv_code_i,
	output logic [2:0] gain_range_sel_o,
	output logic [12:0] full_scale_span_o,
	output logic [11:0] lsb_step_uv_o,
	output logic conv_active_o,
	output logic alert_o,
	output logic alert_oe_b_o
);
	localparam int DW = $clog2(OSC_DIV + 1);
	typedef enum logic [2:0] {
		SN_IDLE, SN_ADDR, SN_ACK_GC, SN_GCDATA, SN_ACK_RST, SN_ACK_ARA, SN_TX, SN_SKIP
	} arc_sn_t;

	arc_conv_if cif ();
	logic [DW-1:0] div_reg;
	logic [15:0] cfg_reg;
	logic [15:0] upper_limit_reg;
	logic [15:0] lower_limit_reg;
	logic [15:0] data_reg;
	logic gc_rst_reg;
	logic ara_win_reg;
	logic cmp_act_reg;
	logic cmp_hi_reg;
	logic [2:0] vio_reg;
	logic [3:0] rdy_cnt_reg;
	logic rdy_hold_reg;
	logic alert_low_reg;
	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;
	logic [6:0] addr_s1, addr_s2;
	arc_sn_t sn_reg;
	logic [2:0] bit_reg;
	logic [7:0] sh_reg;
	logic drv_reg;

	// Oscillator tick: the block clock divided down to the converter rate
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_reg <= '0;
		end else if (div_reg == DW'(OSC_DIV - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end
	assign cif.tick = (div_reg == DW'(OSC_DIV - 1));

	// Register decode
	logic wr_cfg, rd_data;
	assign wr_cfg = reg_wr_i && (reg_addr_i == arc_pkg::OFF_CONFIG);
	assign rd_data = reg_rd_i && (reg_addr_i == arc_pkg::OFF_DATA);

	// Configuration fields
	logic [1:0] que;
	logic win, pol, latch, que_off, rdy_mode;
	logic [2:0] eff_gain;
	assign que = cfg_reg[arc_pkg::CF_QUE +: 2];
	assign win = cfg_reg[arc_pkg::CF_WIN];
	assign pol = cfg_reg[arc_pkg::CF_POL];
	assign latch = cfg_reg[arc_pkg::CF_LATCH];
	assign que_off = (que == arc_pkg::Q_OFF);
	assign eff_gain = HAS_GAIN ? cfg_reg[arc_pkg::CF_GAIN +: 3] : arc_pkg::FIXED_GAIN;
	assign rdy_mode = upper_limit_reg[15] && !lower_limit_reg[15] && !que_off;

	// Timer control; the start flag itself is never stored
	assign cif.clr = gc_rst_reg;
	assign cif.go = wr_cfg && reg_wdata_i[arc_pkg::CF_START]
		&& reg_wdata_i[arc_pkg::CF_MODE];
	assign cif.cont_en = !cfg_reg[arc_pkg::CF_MODE];
	assign cif.period = arc_pkg::RATE_TICKS[cfg_reg[arc_pkg::CF_RATE +: 3]];
	assign conv_active_o = cif.busy;

	arc_conv_timer u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.bus(cif.tmr)
	);

	// Software registers; general-call reset restores the power-up values
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_reg <= arc_pkg::CFG_RST;
			upper_limit_reg <= arc_pkg::UPPER_RST;
			lower_limit_reg <= arc_pkg::LOWER_RST;
		end else if (gc_rst_reg) begin
			cfg_reg <= arc_pkg::CFG_RST;
			upper_limit_reg <= arc_pkg::UPPER_RST;
			lower_limit_reg <= arc_pkg::LOWER_RST;
		end else if (reg_wr_i) begin
			if (wr_cfg) begin
				cfg_reg <= {1'b0, reg_wdata_i[14:0]};
			end
			if (reg_addr_i == arc_pkg::OFF_UPPER) begin
				upper_limit_reg <= reg_wdata_i;
			end
			if (reg_addr_i == arc_pkg::OFF_LOWER) begin
				lower_limit_reg <= reg_wdata_i;
			end
		end
	end

	// Result capture, left-justified so limits compare as signed words
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			data_reg <= '0;
		end else if (gc_rst_reg) begin
			data_reg <= '0;
		end else if (cif.conv_done) begin
			data_reg <= {conv_code_i, 4'h0};
		end
	end

	// Range outputs change only as a conversion starts
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gain_range_sel_o <= arc_pkg::FIXED_GAIN;
			full_scale_span_o <= 13'(arc_pkg::FSR_MV[arc_pkg::FIXED_GAIN]);
			lsb_step_uv_o <= 12'(arc_pkg::FSR_MV[arc_pkg::FIXED_GAIN]
				* arc_pkg::UV_PER_SPAN_MV / arc_pkg::CODE_LEVELS);
		end else if (cif.conv_start) begin
			gain_range_sel_o <= eff_gain;
			full_scale_span_o <= 13'(arc_pkg::FSR_MV[eff_gain]);
			lsb_step_uv_o <= 12'(arc_pkg::FSR_MV[eff_gain]
				* arc_pkg::UV_PER_SPAN_MV / arc_pkg::CODE_LEVELS);
		end
	end

	// Comparator terms on the result being captured this cycle
	logic [15:0] new_res;
	logic above, below, viol, hit, clr_latch;
	logic [2:0] need, vio_inc;
	assign new_res = {conv_code_i, 4'h0};
	assign above = $signed(new_res) > $signed(upper_limit_reg);
	assign below = $signed(new_res) < $signed(lower_limit_reg);
	assign viol = win ? (above || below) : above;
	assign vio_inc = (vio_reg == arc_pkg::N_FOUR) ? vio_reg : vio_reg + 3'h1;
	assign hit = viol && (vio_inc >= need);
	assign clr_latch = rd_data || ara_win_reg;

	// Violations needed before the pin asserts
	always_comb begin
		if (que == arc_pkg::Q_ONE) begin
			need = arc_pkg::N_ONE;
		end else if (que == arc_pkg::Q_TWO) begin
			need = arc_pkg::N_TWO;
		end else begin
			need = arc_pkg::N_FOUR;
		end
	end

	// Comparator state; a violation that completes the queue beats a clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vio_reg <= '0;
			cmp_act_reg <= 1'b0;
			cmp_hi_reg <= 1'b0;
		end else if (gc_rst_reg || que_off || rdy_mode) begin
			vio_reg <= '0;
			cmp_act_reg <= 1'b0;
		end else if (cif.conv_done) begin
			vio_reg <= viol ? vio_inc : 3'h0;
			if (hit) begin
				cmp_act_reg <= 1'b1;
				cmp_hi_reg <= above;
			end else if (!latch && (win ? !viol : below)) begin
				cmp_act_reg <= 1'b0;
			end else if (latch && clr_latch) begin
				cmp_act_reg <= 1'b0;
			end
		end else if (latch && clr_latch) begin
			cmp_act_reg <= 1'b0;
		end
	end

	// Conversion-ready: timed pulse when continuous, held level when single
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdy_cnt_reg <= '0;
			rdy_hold_reg <= 1'b0;
		end else if (gc_rst_reg) begin
			rdy_cnt_reg <= '0;
			rdy_hold_reg <= 1'b0;
		end else begin
			if (cif.conv_done && cif.cont_en) begin
				rdy_cnt_reg <= 4'(arc_pkg::READY_TICKS);
			end else if (cif.tick && rdy_cnt_reg != 4'h0) begin
				rdy_cnt_reg <= rdy_cnt_reg - 4'h1;
			end
			if (cif.conv_done && !cif.cont_en) begin
				rdy_hold_reg <= 1'b1;
			end else if (cif.conv_start || rd_data) begin
				rdy_hold_reg <= 1'b0;
			end
		end
	end

	// Alert pin, registered; active-high assertion means letting go of the line
	logic asrt;
	assign asrt = rdy_mode ? (rdy_cnt_reg != 4'h0 || rdy_hold_reg) : cmp_act_reg;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alert_low_reg <= 1'b0;
		end else begin
			alert_low_reg <= !que_off && (asrt ^ pol);
		end
	end
	assign alert_o = 1'b0;
	assign alert_oe_b_o = !alert_low_reg;

	// Bus pins and address strap pass two flip-flops first
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			addr_s1 <= '0;
			addr_s2 <= '0;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			addr_s1 <= dev_addr_i;
			addr_s2 <= addr_s1;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, ara_armed;
	logic [7:0] sh_next;
	assign scl_rise = scl_s2 && !scl_d;
	assign scl_fall = !scl_s2 && scl_d;
	assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
	assign bus_stop = scl_s2 && scl_d && !sda_d && sda_s2;
	assign sh_next = {sh_reg[6:0], sda_s2};
	assign ara_armed = latch && cmp_act_reg && !rdy_mode && !que_off;

	// Bus listener: general-call reset and alert response only
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sn_reg <= SN_IDLE;
			bit_reg <= '0;
			sh_reg <= '0;
			drv_reg <= 1'b0;
			gc_rst_reg <= 1'b0;
			ara_win_reg <= 1'b0;
		end else begin
			gc_rst_reg <= 1'b0;
			ara_win_reg <= 1'b0;
			if (bus_stop) begin
				sn_reg <= SN_IDLE;
				drv_reg <= 1'b0;
			end else if (bus_start) begin
				sn_reg <= SN_ADDR;
				bit_reg <= '0;
				drv_reg <= 1'b0;
			end else begin
				unique case (sn_reg)
					SN_IDLE: begin
					end
					SN_ADDR, SN_GCDATA: begin
						if (scl_rise) begin
							sh_reg <= sh_next;
							bit_reg <= bit_reg + 3'h1;
							if (bit_reg == 3'h7) begin
								if (sn_reg == SN_GCDATA) begin
									sn_reg <= (sh_next == arc_pkg::GC_RESET_BYTE)
										? SN_ACK_RST : SN_SKIP;
								end else if (sh_next == arc_pkg::GC_ADDR_BYTE) begin
									sn_reg <= SN_ACK_GC;
								end else if (sh_next == arc_pkg::ARA_RD_BYTE && ara_armed) begin
									sn_reg <= SN_ACK_ARA;
								end else begin
									sn_reg <= SN_SKIP;
								end
							end
						end
					end
					SN_ACK_GC, SN_ACK_RST, SN_ACK_ARA: begin
						// First fall pulls SDA low for the ninth bit, second fall ends it
						if (scl_fall) begin
							if (!drv_reg) begin
								drv_reg <= 1'b1;
							end else if (sn_reg == SN_ACK_GC) begin
								drv_reg <= 1'b0;
								bit_reg <= '0;
								sn_reg <= SN_GCDATA;
							end else if (sn_reg == SN_ACK_RST) begin
								drv_reg <= 1'b0;
								gc_rst_reg <= 1'b1;
								sn_reg <= SN_SKIP;
							end else begin
								sh_reg <= {addr_s2, cmp_hi_reg};
								drv_reg <= !addr_s2[6];
								bit_reg <= '0;
								sn_reg <= SN_TX;
							end
						end
					end
					SN_TX: begin
						if (scl_rise) begin
							if (!drv_reg && !sda_s2) begin
								sn_reg <= SN_SKIP;
							end else if (bit_reg == 3'h7) begin
								ara_win_reg <= 1'b1;
								sn_reg <= SN_SKIP;
							end else begin
								bit_reg <= bit_reg + 3'h1;
							end
						end else if (scl_fall) begin
							drv_reg <= !sh_reg[6];
							sh_reg <= {sh_reg[6:0], 1'b0};
						end
					end
					SN_SKIP: begin
						if (scl_fall) begin
							drv_reg <= 1'b0;
						end
					end
				endcase
			end
		end
	end
	assign sda_o = 1'b0;
	assign sda_oe_b_o = !drv_reg;

	// Read data stand for the one cycle after the strobe
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				arc_pkg::OFF_DATA: reg_rdata_o <= data_reg;
				arc_pkg::OFF_CONFIG: reg_rdata_o <= {!cif.busy, cfg_reg[14:0]};
				arc_pkg::OFF_LOWER: reg_rdata_o <= lower_limit_reg;
				arc_pkg::OFF_UPPER: reg_rdata_o <= upper_limit_reg;
				arc_pkg::OFF_STATUS: reg_rdata_o <= {12'h000, rdy_mode, cmp_hi_reg,
					cmp_act_reg, cif.busy};
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end
endmodule : arc_ctrl_top

// ---- verification/arc_bus_ctl.sv ----
// Two-wire bus controller model with alert-response and general-call frames
`timescale 1ns/1ps
module arc_bus_ctl (
	input wire logic ref_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// Both lines rest high on the pull-ups outside frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Quarter of the 160 ns bus clock
	task automatic q4;
		repeat (4) @(posedge ref_clk_i);
	endtask : q4
	// Data set in the low phase, sampled off the edge in the high phase
	task automatic bit_x(input logic b, output logic r);
		q4();
		sda_o <= b;
		q4();
		scl_o <= 1'b1;
		q4();
		@(negedge ref_clk_i);
		r = sda_i;
		q4();
		scl_o <= 1'b0;
	endtask : bit_x
	// MSB first; ninth bit released, so a reply byte ends in a not-acknowledge
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(1'b1, a);
	endtask : xb
	// Whole frame of two bytes; a rival reply byte models a competing device
	task automatic frame(input logic [7:0] b0, input logic [7:0] b1, output logic [7:0] rx);
		logic [7:0] d;
		sda_o <= 1'b0;
		q4();
		scl_o <= 1'b0;
		xb(b0, d);
		xb(b1, rx);
		q4();
		sda_o <= 1'b0;
		q4();
		scl_o <= 1'b1;
		q4();
		sda_o <= 1'b1;
		q4();
	endtask : frame
endmodule : arc_bus_ctl

// ---- verification/arc_ctrl_properties.sv ----
// Checker: conversion timing, range outputs and pin properties
`timescale 1ns/1ps
module arc_ctrl_props #(
	parameter int unsigned OSC_DIV = 100
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic sda_o,
	input wire logic sda_oe_b_o,
	input wire logic [2:0] gain_range_sel_o,
	input wire logic [12:0] full_scale_span_o,
	input wire logic [11:0] lsb_step_uv_o,
	input wire logic conv_active_o,
	input wire logic alert_o,
	input wire logic alert_oe_b_o
);
	// Shortest conversion: power-up plus fastest rate, one tick of slack
	localparam int unsigned MINC = (arc_pkg::PWRUP_TICKS + arc_pkg::RATE_TICKS[6] - 1) * OSC_DIV;
	logic [15:0] cfg_q;
	logic [2:0] wr_hist;
	int unsigned run_len;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Shadow of the configuration word and of recent writes
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_q <= arc_pkg::CFG_RST;
			wr_hist <= 3'h0;
		end else begin
			wr_hist <= {wr_hist[1:0], reg_wr_i};
			if (reg_wr_i && reg_addr_i == arc_pkg::OFF_CONFIG) begin
				cfg_q <= reg_wdata_i;
			end
		end
	end
	// Length of the current busy stretch
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_len <= 0;
		end else begin
			run_len <= conv_active_o ? run_len + 1 : 0;
		end
	end
	// Codes above five repeat the smallest span
	function automatic logic [12:0] span_of(input logic [2:0] g);
		return g == 3'h0 ? 13'h1800 : (g > 3'h5 ? 13'h0100 : 13'h1000 >> (g - 3'h1));
	endfunction : span_of
	property p_span; $stable(gain_range_sel_o) |-> full_scale_span_o == span_of(gain_range_sel_o); endproperty
	a_span: assert property (p_span) else $error("span does not match gain code");
	property p_lsb; $stable(full_scale_span_o) |-> int'(lsb_step_uv_o) * 2048 == int'(full_scale_span_o) * 1000; endproperty
	a_lsb: assert property (p_lsb) else $error("code step does not match span");
	property p_len; $fell(conv_active_o) |-> run_len >= MINC; endproperty
	a_len: assert property (p_len) else $error("conversion ended too early");
	property p_start; reg_wr_i && reg_addr_i == arc_pkg::OFF_CONFIG && reg_wdata_i[15] && reg_wdata_i[8] && !conv_active_o |-> ##[1:3] conv_active_o; endproperty
	a_start: assert property (p_start) else $error("start write did not begin a conversion");
	property p_idle; cfg_q[8] && !conv_active_o && !reg_wr_i && wr_hist == 3'h0 |=> !conv_active_o; endproperty
	a_idle: assert property (p_idle) else $error("conversion began without a start");
	property p_cont; !cfg_q[8] && $fell(conv_active_o) |-> ##[0:2] conv_active_o; endproperty
	a_cont: assert property (p_cont) else $error("continuous mode stopped converting");
	property p_cfg_rd; reg_rd_i && reg_addr_i == arc_pkg::OFF_CONFIG |=> reg_rdata_o[14:0] == cfg_q[14:0]; endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("configuration read back wrong");
	property p_qoff; cfg_q[1:0] == arc_pkg::Q_OFF && $past(cfg_q[1:0]) == arc_pkg::Q_OFF |-> alert_oe_b_o; endproperty
	a_qoff: assert property (p_qoff) else $error("alert line pulled with comparator off");
	property p_od; alert_o == 1'b0 && sda_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("open-drain output drives high");
	c_conv: cover property ($fell(conv_active_o));
	c_alert: cover property ($fell(alert_oe_b_o));
	c_reply: cover property ($fell(sda_oe_b_o));
endmodule : arc_ctrl_props
bind arc_ctrl_top arc_ctrl_props #(.OSC_DIV(OSC_DIV)) u_props (.ref_clk_i(ref_clk_i),
	.rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
	.gain_range_sel_o(gain_range_sel_o), .full_scale_span_o(full_scale_span_o),
	.lsb_step_uv_o(lsb_step_uv_o), .conv_active_o(conv_active_o), .alert_o(alert_o),
	.alert_oe_b_o(alert_oe_b_o));

// ---- verification/arc_ctrl_top_tb_top.sv ----
// Testbench: registers, conversions, comparator, ready pin and alert response
`timescale 1ns/1ps
module arc_ctrl_top_tb_top;
	localparam int DIV = 2;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [11:0] code = 12'h000;
	logic [15:0] rdata;
	logic scl;
	logic m_sda;
	logic sda_oe_b;
	logic sda_w;
	logic [2:0] gsel;
	logic [12:0] span;
	logic [11:0] lsb;
	logic act;
	logic aoe_b;
	int n_errors = 0;
	int check_count = 0;
	// Comparator table: code, mode bits (window, polarity, latch, queue), pin
	logic [23:0] tv [19] = '{24'h500_00_0, 24'h300_00_0, 24'h100_00_1, 24'h300_10_1,
		24'h100_10_0, 24'h300_10_1, 24'h500_14_0, 24'h300_14_0, 24'h500_11_1, 24'h300_11_1,
		24'h500_11_1, 24'h500_11_0, 24'h500_13_1, 24'h500_18_1, 24'h300_18_0,
		24'h500_12_1, 24'h500_12_1, 24'h500_12_1, 24'h500_12_0};
	// Wired-AND of both open-drain parties on the data line
	assign sda_w = sda_oe_b & m_sda;
	arc_ctrl_top #(.OSC_DIV(DIV)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_b_o(sda_oe_b),
		.dev_addr_i(7'h49), .conv_code_i(code), .gain_range_sel_o(gsel),
		.full_scale_span_o(span), .lsb_step_uv_o(lsb), .conv_active_o(act), .alert_o(),
		.alert_oe_b_o(aoe_b));
	arc_bus_ctl ctl (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Step past a rising edge so outputs have settled
	task automatic cyc;
		@(posedge ref_clk_i);
		#1;
	endtask : cyc
	// Strobes drop for one cycle between accesses
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc();
		wr <= 1'b0;
		cyc();
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
		addr <= a;
		rd <= 1'b1;
		cyc();
		rd <= 1'b0;
		chk(rdata, exp);
		cyc();
	endtask : rd_reg
	function automatic logic [15:0] cf(input logic [2:0] g, input logic [2:0] r,
		input logic [4:0] m);
		return {1'b1, 3'h0, g, 1'b1, r, m};
	endfunction : cf
	function automatic logic [15:0] near(input int a, input int b, input int t);
		return 16'(a - b <= t && b - a <= t);
	endfunction : near
	// Busy time in cycles, bounded so a stuck converter cannot hang the run
	task automatic idle(output int n);
		n = 0;
		while (act === 1'b1 && n < 40000) begin
			cyc();
			n++;
		end
		repeat (6) cyc();
	endtask : idle
	task automatic conv(input logic [11:0] c, input logic [15:0] d, output int n);
		code <= c;
		wr_reg(arc_pkg::OFF_CONFIG, d);
		idle(n);
		n += 1;
	endtask : conv
	task automatic low_pulse(output int n);
		n = 0;
		while (aoe_b !== 1'b0 && n < 2000) begin
			cyc();
			n++;
		end
		n = 0;
		while (aoe_b === 1'b0 && n < 100) begin
			cyc();
			n++;
		end
	endtask : low_pulse
	initial begin
		#1_000_000;
		n_errors++;
		end_of_test();
	end
	initial begin
		int n;
		logic [7:0] rx;
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		cyc();
		rd_reg(arc_pkg::OFF_CONFIG, 16'h8583);
		rd_reg(arc_pkg::OFF_LOWER, 16'h8000);
		rd_reg(arc_pkg::OFF_UPPER, 16'h7FFF);
		rd_reg(5'h14, 16'h0000);
		chk(act, 1'b0);
		$display("test reset done");
		// Every rate once, gain codes cycling, converter idle after each shot
		for (int i = 0; i < 7; i++) begin
			conv(12'h000, cf(3'(i % 6), 3'(i), 5'h03), n);
			chk(gsel, 16'(i % 6));
			chk(span, 16'(arc_pkg::FSR_MV[i % 6]));
			chk(lsb, 16'(arc_pkg::FSR_MV[i % 6] * 1000 / 2048));
			chk(near(n, (25 + 1_000_000 / int'(arc_pkg::RATE_SPS[i])) * DIV, 2 * DIV), 1);
			rd_reg(arc_pkg::OFF_CONFIG, cf(3'(i % 6), 3'(i), 5'h03));
		end
		$display("test range and rate done");
		wr_reg(arc_pkg::OFF_UPPER, 16'h4000);
		wr_reg(arc_pkg::OFF_LOWER, 16'h2000);
		for (int i = 0; i < 19; i++) begin
			conv(tv[i][23:12], cf(3'h2, 3'h7, tv[i][8:4]), n);
			chk(aoe_b, tv[i][0]);
			if (i == 7) begin
				rd_reg(arc_pkg::OFF_DATA, 16'h3000);
				chk(aoe_b, 1'b1);
			end
		end
		$display("test comparator done");
		wr_reg(arc_pkg::OFF_UPPER, 16'h8000);
		wr_reg(arc_pkg::OFF_LOWER, 16'h0000);
		conv(12'h123, cf(3'h2, 3'h7, 5'h14), n);
		chk(aoe_b, 1'b0);
		rd_reg(arc_pkg::OFF_DATA, 16'h1230);
		chk(aoe_b, 1'b1);
		// Continuous ready pulses; a gain change waits for the next conversion
		wr_reg(arc_pkg::OFF_CONFIG, 16'h04E0);
		low_pulse(n);
		chk(near(n, 8 * DIV, 1), 1);
		wr_reg(arc_pkg::OFF_CONFIG, 16'h00E0);
		chk(gsel, 16'h0002);
		low_pulse(n);
		chk(gsel, 16'h0000);
		wr_reg(arc_pkg::OFF_CONFIG, 16'h05E3);
		idle(n);
		chk(act, 1'b0);
		$display("test ready pin done");
		wr_reg(arc_pkg::OFF_UPPER, 16'h4000);
		wr_reg(arc_pkg::OFF_LOWER, 16'h2000);
		conv(12'h500, cf(3'h2, 3'h7, 5'h14), n);
		ctl.frame(8'h19, 8'h90, rx);
		cyc();
		chk(rx, 8'h90);
		chk(aoe_b, 1'b0);
		ctl.frame(8'h19, 8'hFF, rx);
		cyc();
		chk(rx, 8'h93);
		chk(aoe_b, 1'b1);
		conv(12'h100, cf(3'h2, 3'h7, 5'h14), n);
		ctl.frame(8'h19, 8'hFF, rx);
		cyc();
		chk(rx, 8'h92);
		$display("test alert response done");
		wr_reg(arc_pkg::OFF_CONFIG, 16'h0583);
		wr_reg(arc_pkg::OFF_LOWER, 16'h1234);
		ctl.frame(8'h00, 8'h06, rx);
		cyc();
		rd_reg(arc_pkg::OFF_LOWER, 16'h8000);
		rd_reg(arc_pkg::OFF_UPPER, 16'h7FFF);
		$display("test general reset done");
		end_of_test();
	end
endmodule : arc_ctrl_top_tb_top
